// [sec_host.sv]
// Host controller model driving the serial EEPROM command port.
// Assumes an 80 ns link oscillator; the serial clock idles low between frames.
`default_nettype none
module sec_host (
    input  wire logic        lnk_osc,
    input  wire logic        sdo_line,
    output var  logic        serial_clock,
    output var  logic        chip_select,
    output var  logic        serial_data_in,
    output var  logic        res_stb,
    output var  logic [15:0] res_word
);
    timeunit 1ns;
    timeprecision 100ps;
    logic smp;
    int   hold_extra = 0;
    initial begin
        serial_clock = 1'b0;
        chip_select = 1'b0;
        serial_data_in = 1'b0;
        res_stb = 1'b0;
        res_word = 16'h0000;
    end
    // A stretched low phase checks that the device simply waits for the clock.
    task automatic step(input logic b);
        @(posedge lnk_osc) #1;
        serial_data_in = b;
        repeat (hold_extra) @(posedge lnk_osc);
        @(posedge lnk_osc) #1;
        smp = sdo_line;
        serial_clock = 1'b1;
        repeat (2) @(posedge lnk_osc);
        #1 serial_clock = 1'b0;
    endtask
    task automatic idle_pulses(input int n);
        repeat (2 * n) @(posedge lnk_osc) #1 serial_clock = ~serial_clock;
    endtask
    task automatic close;
        @(posedge lnk_osc) #1;
        chip_select = 1'b0;
        serial_data_in = ~serial_data_in;
        repeat (4) @(posedge lnk_osc);
    endtask
    task automatic frame(input logic [31:0] bits, input int n, input bit keep);
        @(posedge lnk_osc) #1;
        chip_select = 1'b1;
        for (int i = n - 1; i >= 0; i--) step(bits[i]);
        if (!keep) close();
    endtask
    task automatic report(input logic [15:0] w);
        res_word = w;
        res_stb = 1'b1;
        @(posedge lnk_osc) #1;
        res_stb = 1'b0;
    endtask
    task automatic fetch(input int words, input int w);
        logic [15:0] acc;
        step(1'b0);
        report({15'h0000, smp});
        repeat (words) begin
            acc = 16'h0000;
            repeat (w) begin
                step(1'b0);
                acc = {acc[14:0], smp};
            end
            report(acc);
        end
        close();
    endtask
    // Polling is bounded so a device that never reports ready cannot hang the host.
    task automatic await_ready;
        int k;
        @(posedge lnk_osc) #1;
        chip_select = 1'b1;
        repeat (2) @(posedge lnk_osc);
        report({15'h0000, sdo_line});
        k = 0;
        do begin
            @(posedge lnk_osc);
            k++;
        end while (sdo_line !== 1'b1 && k < 200);
        report({15'h0000, sdo_line});
        close();
    endtask
endmodule
`default_nettype wire

// [sec_pkg.sv]
// Constants and types of the serial EEPROM command port.
// Assumes one system clock of 50 MHz and a host-driven serial clock.
// Overview of operation
// RL1 - Instruction opens with a start bit one
// RL2 - Opcode two bits, address, then data
// RL3 - Host keeps select high, input stable
// RL4 - Stopped serial clock freezes all link state
// RL5 - Select low without programming means standby
// RL6 - Read shifts a zero, then the word
// RL7 - Output changes on rising edges, read only
// RL8 - Read continues at next higher address
// RL9 - Read address wraps until select low
// RL10 - Power up locked, programming ignored
// RL11 - Unlocked until lock instruction or power
// RL12 - Host ends write with select low
// RL13 - Select fall starts programming when unlocked
// RL14 - Raised select shows busy zero, ready one
// RL15 - Status withheld late, cleared by start
// RL16 - Fill-all programs every word with data
// RL17 - Lock blocks programming until next unlock
// RL18 - Word erase starts on select fall
// RL19 - Erase-all sets every bit to one
// RL20 - Opcodes: read 10, write 01, erase 11
// RL21 - Opcode 00 sub-command in top address bits
// RL22 - Byte or word mode address layout
// RL23 - Wrong bit count drops programming commands
// RL24 - Host waits for ready before next instruction
// RL25 - Word erase sets word to all ones
// RL26 - Locked programming leaves array and status untouched
`default_nettype none
package sec_pkg;
    localparam logic [1:0] OP_EXT = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] SUB_LOCK = 2'h0;
    localparam logic [1:0] SUB_FILL = 2'h1;
    localparam logic [1:0] SUB_CLEAR = 2'h2;
    localparam logic [1:0] SUB_UNLOCK = 2'h3;
    localparam int MEM_BYTES = 256;
    localparam logic [4:0] ALEN_BYTE = 5'h09;
    localparam logic [4:0] ALEN_WORD = 5'h08;
    localparam logic [4:0] DLEN_BYTE = 5'h08;
    localparam logic [4:0] DLEN_WORD = 5'h10;
    localparam logic [1:0] OPC_LEN = 2'h2;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_WP_NS = 5000000;
    localparam int PROG_CYCLES = T_WP_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        LNK_IDLE, LNK_OPC, LNK_ADDR, LNK_DATA, LNK_READ, LNK_DONE
    } sec_link_e;
    typedef enum logic [1:0] {
        PRG_NONE, PRG_WORD, PRG_FILL
    } sec_prog_e;
endpackage
`default_nettype wire

// [sec_port.sv]
// Serial EEPROM command port: frame decoder, read streamer and programming control.
// Assumes the host keeps select, clock and data timing; the array changes only
// while the host waits for ready, so link logic reads it as a quasi-static value.
`default_nettype none
module sec_port #(
    parameter int PROG_CYCLES = sec_pkg::PROG_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic serial_clock,
    input  wire logic chip_select,
    input  wire logic serial_data_in,
    input  wire logic word_width_select,
    output var  logic serial_data_out,
    output var  logic serial_data_out_oe_n
);
    logic [7:0]         mem_q [sec_pkg::MEM_BYTES];
    sec_pkg::sec_link_e fsm_q;
    logic [4:0]         cnt_q;
    logic               lrst_s1_q;
    logic               lrst_q;
    logic               lwide_s1_q;
    logic               lwide_q;
    logic [1:0]         op_q;
    logic [8:0]         fld_q;
    logic [15:0]        data_q;
    logic               full_q;
    logic               extra_q;
    logic               start_tog_q;
    logic               cmd_tog_q;
    logic [7:0]         rd_addr_q;
    logic [15:0]        sh_q;
    logic [4:0]         rd_cnt_q;
    logic               rd_bit_q;
    logic               rd_act_q;
    logic [4:0]         alen;
    logic [4:0]         dlen;
    logic               addr_last;
    logic [8:0]         fld_nxt;
    logic [7:0]         rd_start;
    logic [7:0]         rd_next;
    logic [4:0]         cs_s_q;
    logic [2:0]         stt_s_q;
    logic [1:0]         cmd_s_q;
    logic [1:0]         bit_s_q;
    logic [1:0]         act_s_q;
    logic [1:0]         wide_s_q;
    logic               cs_fall;
    logic               cs_rise;
    logic               start_ev;
    logic               new_cmd;
    logic [1:0]         sub;
    logic               seen_q;
    logic               unlocked_q;
    logic               start_q;
    logic               status_show_q;
    sec_pkg::sec_prog_e pend_q;
    logic [7:0]         pend_addr_q;
    logic [15:0]        pend_data_q;
    logic               pend_wide_q;
    logic               busy;
    logic               done;
    logic               prog_ok;

    function automatic logic [15:0] word_at(input logic [7:0] a, input logic w);
        logic [7:0] hi;
        hi = {a[6:0], 1'b0};
        word_at = w ? {mem_q[hi], mem_q[hi | 8'h01]} : {mem_q[a], 8'h00};
    endfunction

    // Link domain. Everything here advances only on serial clock edges, so a
    // stopped clock freezes the frame where it stands.
    always_ff @(posedge serial_clock) begin // RL4
        lrst_s1_q <= srst;
        lrst_q <= lrst_s1_q;
        lwide_s1_q <= word_width_select;
        lwide_q <= lwide_s1_q;
    end

    assign alen = lwide_q ? sec_pkg::ALEN_WORD : sec_pkg::ALEN_BYTE; // RL22
    assign dlen = lwide_q ? sec_pkg::DLEN_WORD : sec_pkg::DLEN_BYTE;
    assign addr_last = (fsm_q == sec_pkg::LNK_ADDR) && (cnt_q == alen - 5'h01);
    assign fld_nxt = {fld_q[7:0], serial_data_in};
    assign rd_start = lwide_q ? {1'b0, fld_nxt[6:0]} : fld_nxt[7:0];
    assign rd_next = lwide_q ? {1'b0, rd_addr_q[6:0] + 7'h01} : rd_addr_q + 8'h01; // RL9

    // Select low clears the frame at once: this is the standby state, and a
    // new instruction can only begin with a fresh start bit.
    always_ff @(posedge serial_clock or negedge chip_select) begin
        if (!chip_select) begin
            fsm_q <= sec_pkg::LNK_IDLE; // RL5
            cnt_q <= 5'h00;
        end else begin
            case (fsm_q)
                sec_pkg::LNK_IDLE: begin
                    if (serial_data_in) begin
                        fsm_q <= sec_pkg::LNK_OPC; // RL1
                        cnt_q <= 5'h00;
                    end
                end
                sec_pkg::LNK_OPC: begin
                    if (cnt_q == 5'(sec_pkg::OPC_LEN - 2'h1)) begin
                        fsm_q <= sec_pkg::LNK_ADDR; // RL2
                        cnt_q <= 5'h00;
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                sec_pkg::LNK_ADDR: begin
                    cnt_q <= addr_last ? 5'h00 : cnt_q + 5'h01;
                    if (addr_last) begin
                        if (op_q == sec_pkg::OP_READ) begin
                            fsm_q <= sec_pkg::LNK_READ; // RL20
                        end else if (op_q == sec_pkg::OP_WRITE ||
                                     (op_q == sec_pkg::OP_EXT && fld_nxt[8:7] == sec_pkg::SUB_FILL && !lwide_q) ||
                                     (op_q == sec_pkg::OP_EXT && fld_nxt[7:6] == sec_pkg::SUB_FILL && lwide_q)) begin
                            fsm_q <= sec_pkg::LNK_DATA; // RL21
                        end else begin
                            fsm_q <= sec_pkg::LNK_DONE;
                        end
                    end
                end
                sec_pkg::LNK_DATA: begin
                    if (cnt_q == dlen - 5'h01) begin
                        fsm_q <= sec_pkg::LNK_DONE;
                    end
                    cnt_q <= cnt_q + 5'h01;
                end
                sec_pkg::LNK_READ, sec_pkg::LNK_DONE: fsm_q <= fsm_q;
                default: fsm_q <= sec_pkg::LNK_IDLE;
            endcase
        end
    end

    // Frame fields outlive the select fall, because the system side decodes
    // them only after it has seen that fall through its synchroniser.
    always_ff @(posedge serial_clock) begin
        if (lrst_q) begin
            op_q <= 2'h0;
            fld_q <= 9'h000;
            data_q <= 16'h0000;
            full_q <= 1'b0;
            extra_q <= 1'b0;
            start_tog_q <= 1'b0;
            cmd_tog_q <= 1'b0;
        end else begin
            case (fsm_q)
                sec_pkg::LNK_IDLE: begin
                    if (serial_data_in && chip_select) begin
                        start_tog_q <= ~start_tog_q; // RL15
                        full_q <= 1'b0;
                        extra_q <= 1'b0;
                    end
                end
                sec_pkg::LNK_OPC: op_q <= {op_q[0], serial_data_in}; // RL2
                sec_pkg::LNK_ADDR: begin
                    fld_q <= fld_nxt;
                    if (addr_last) begin
                        cmd_tog_q <= ~cmd_tog_q;
                    end
                end
                sec_pkg::LNK_DATA: begin
                    data_q <= {data_q[14:0], serial_data_in};
                    if (cnt_q == dlen - 5'h01) begin
                        full_q <= 1'b1;
                    end
                end
                sec_pkg::LNK_DONE: extra_q <= 1'b1; // RL23
                default: extra_q <= extra_q;
            endcase
        end
    end

    always_ff @(posedge serial_clock or negedge chip_select) begin
        if (!chip_select) begin
            rd_addr_q <= 8'h00;
            sh_q <= 16'h0000;
            rd_cnt_q <= 5'h00;
            rd_bit_q <= 1'b0;
            rd_act_q <= 1'b0;
        end else if (addr_last && op_q == sec_pkg::OP_READ) begin
            rd_addr_q <= rd_start;
            sh_q <= word_at(rd_start, lwide_q); // RL6
            rd_cnt_q <= 5'h00;
            rd_bit_q <= 1'b0; // RL6
            rd_act_q <= 1'b1; // RL7
        end else if (fsm_q == sec_pkg::LNK_READ) begin
            rd_bit_q <= sh_q[15]; // RL7
            if (rd_cnt_q == dlen - 5'h01) begin
                rd_cnt_q <= 5'h00;
                rd_addr_q <= rd_next; // RL8
                sh_q <= word_at(rd_next, lwide_q);
            end else begin
                rd_cnt_q <= rd_cnt_q + 5'h01;
                sh_q <= {sh_q[14:0], 1'b0};
            end
        end
    end

    // System domain synchronisers. Select passes two stages more than the
    // command toggle, so a command clocked just before the fall is seen.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cs_s_q <= 5'h00;
            stt_s_q <= 3'h0;
            cmd_s_q <= 2'h0;
            bit_s_q <= 2'h0;
            act_s_q <= 2'h0;
            wide_s_q <= 2'h0;
        end else begin
            cs_s_q <= {cs_s_q[3:0], chip_select};
            stt_s_q <= {stt_s_q[1:0], start_tog_q};
            cmd_s_q <= {cmd_s_q[0], cmd_tog_q};
            bit_s_q <= {bit_s_q[0], rd_bit_q};
            act_s_q <= {act_s_q[0], rd_act_q};
            wide_s_q <= {wide_s_q[0], word_width_select};
        end
    end

    assign cs_fall = cs_s_q[4] && !cs_s_q[3];
    assign cs_rise = cs_s_q[2] && !cs_s_q[3];
    assign start_ev = stt_s_q[2] ^ stt_s_q[1];
    assign new_cmd = cs_fall && (cmd_s_q[1] != seen_q);
    assign sub = wide_s_q[1] ? fld_q[7:6] : fld_q[8:7]; // RL21
    assign prog_ok = unlocked_q && !busy && !extra_q; // RL26 RL23
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            seen_q <= 1'b0;
            unlocked_q <= 1'b0; // RL10
        end else if (new_cmd) begin
            seen_q <= cmd_s_q[1];
            if (op_q == sec_pkg::OP_EXT && sub == sec_pkg::SUB_UNLOCK) begin
                unlocked_q <= 1'b1; // RL11
            end else if (op_q == sec_pkg::OP_EXT && sub == sec_pkg::SUB_LOCK) begin
                unlocked_q <= 1'b0; // RL17
            end
        end
    end

    // Programming is decided on the select fall and applied when the timer ends.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            start_q <= 1'b0;
            pend_q <= sec_pkg::PRG_NONE;
            pend_addr_q <= 8'h00;
            pend_data_q <= 16'h0000;
            pend_wide_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            pend_wide_q <= wide_s_q[1];
            if (done) begin
                pend_q <= sec_pkg::PRG_NONE;
            end
            if (new_cmd && prog_ok) begin
                pend_addr_q <= fld_q[7:0];
                case (op_q)
                    sec_pkg::OP_WRITE: begin
                        if (full_q) begin
                            start_q <= 1'b1; // RL13
                            pend_q <= sec_pkg::PRG_WORD;
                            pend_data_q <= data_q;
                        end
                    end
                    sec_pkg::OP_ERASE: begin
                        start_q <= 1'b1; // RL18
                        pend_q <= sec_pkg::PRG_WORD;
                        pend_data_q <= sec_pkg::ERASED_WORD; // RL25
                    end
                    sec_pkg::OP_EXT: begin
                        if (sub == sec_pkg::SUB_FILL && full_q) begin
                            start_q <= 1'b1; // RL16
                            pend_q <= sec_pkg::PRG_FILL;
                            pend_data_q <= data_q;
                        end else if (sub == sec_pkg::SUB_CLEAR) begin
                            start_q <= 1'b1;
                            pend_q <= sec_pkg::PRG_FILL;
                            pend_data_q <= sec_pkg::ERASED_WORD; // RL19
                        end
                    end
                    default: start_q <= 1'b0;
                endcase
            end
        end
    end

    sec_prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .sys_clk (sys_clk),
        .srst    (srst),
        .start   (start_q),
        .busy    (busy),
        .done    (done)
    );
    // In word mode the even byte holds the upper half of the word.
    for (genvar i = 0; i < sec_pkg::MEM_BYTES; i++) begin : g_mem
        localparam logic [7:0] IDX = 8'(i);
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                mem_q[i] <= sec_pkg::ERASED_BYTE;
            end else if (done && pend_q == sec_pkg::PRG_FILL) begin
                mem_q[i] <= (pend_wide_q && !IDX[0]) ? pend_data_q[15:8] : pend_data_q[7:0]; // RL16
            end else if (done && pend_q == sec_pkg::PRG_WORD) begin
                if (pend_wide_q && IDX[7:1] == pend_addr_q[6:0]) begin
                    mem_q[i] <= IDX[0] ? pend_data_q[7:0] : pend_data_q[15:8];
                end else if (!pend_wide_q && IDX == pend_addr_q) begin
                    mem_q[i] <= pend_data_q[7:0];
                end
            end
        end
    end

    // The status flag stays up after the cycle so that ready can be read.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_show_q <= 1'b0;
        end else if (start_ev) begin
            status_show_q <= 1'b0; // RL15
        end else if (cs_rise && busy) begin
            status_show_q <= 1'b1; // RL14
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serial_data_out <= 1'b0;
            serial_data_out_oe_n <= 1'b1;
        end else begin
            serial_data_out <= status_show_q ? !busy : bit_s_q[1]; // RL14
            serial_data_out_oe_n <= !(cs_s_q[2] && (status_show_q || act_s_q[1])); // RL5
        end
    end

    lock_block_a: assert property (@(posedge sys_clk) disable iff (srst) // RL26
        (new_cmd && !unlocked_q) |=> !start_q && !busy [*2])
        else $error("Locked device started programming.");
    extra_drop_a: assert property (@(posedge sys_clk) disable iff (srst) // RL23
        (new_cmd && extra_q && op_q != sec_pkg::OP_READ) |=> !start_q)
        else $error("Overlong frame started programming.");
    unlock_taken_a: assert property (@(posedge sys_clk) disable iff (srst) // RL11
        (new_cmd && op_q == sec_pkg::OP_EXT && sub == sec_pkg::SUB_UNLOCK) |=> unlocked_q)
        else $error("Unlock was not taken.");
    lock_taken_a: assert property (@(posedge sys_clk) disable iff (srst) // RL17
        (new_cmd && op_q == sec_pkg::OP_EXT && sub == sec_pkg::SUB_LOCK) |=> !unlocked_q)
        else $error("Lock was not taken.");
    busy_shown_a: assert property (@(posedge sys_clk) disable iff (srst) // RL14
        (status_show_q && busy && !start_ev) ##1 busy |=> !serial_data_out)
        else $error("Busy not shown as zero.");
    ready_shown_a: assert property (@(posedge sys_clk) disable iff (srst) // RL14
        (status_show_q && !busy && !start_ev) ##1 status_show_q |=> serial_data_out)
        else $error("Ready not shown as one.");
    status_clear_a: assert property (@(posedge sys_clk) disable iff (srst) // RL15
        start_ev |=> !status_show_q)
        else $error("Start bit did not clear status.");
    idle_float_a: assert property (@(posedge sys_clk) disable iff (srst) // RL5
        !cs_s_q[2] |=> serial_data_out_oe_n)
        else $error("Output driven while deselected.");
    lead_zero_a: assert property (@(posedge serial_clock) disable iff (lrst_q || !chip_select) // RL6
        (addr_last && op_q == sec_pkg::OP_READ) |=> !rd_bit_q && rd_act_q)
        else $error("Read did not lead with zero.");
    read_wrap_a: assert property (@(posedge serial_clock) disable iff (lrst_q || !chip_select) // RL9
        (fsm_q == sec_pkg::LNK_READ && rd_cnt_q == dlen - 5'h01 && rd_addr_q == (lwide_q ? 8'h7F : 8'hFF))
        |=> rd_addr_q == 8'h00)
        else $error("Read address did not wrap.");
    read_seen_c: cover property (@(posedge serial_clock) fsm_q == sec_pkg::LNK_READ && rd_cnt_q == 5'h07);
    prog_seen_c: cover property (@(posedge sys_clk) start_q);
    status_seen_c: cover property (@(posedge sys_clk) status_show_q && !busy);
endmodule
`default_nettype wire

// [sec_prog_timer.sv]
// Self-timed programming cycle counter of the serial EEPROM port.
// Assumes a one-cycle start pulse on the system clock.
`default_nettype none
module sec_prog_timer #(
    parameter int CYCLES = sec_pkg::PROG_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic start,
    output var  logic busy,
    output var  logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_q <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1; // RL13
                cnt_q <= '0;
            end else if (busy) begin
                if (cnt_q == LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    busy_start_a: assert property (@(posedge sys_clk) disable iff (srst) // RL13
        (start && !busy) |=> busy [*2])
        else $error("Programming did not start.");
endmodule
`default_nettype wire

// [tb_sec_port.sv]
// Self-checking bench of the serial EEPROM command port in byte and word mode.
// Assumes the host model sec_host and a shortened programming time.
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_sec_port;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PROG = 60;
    logic        sys_clk;
    logic        srst;
    logic        lnk_osc;
    logic        word_width_select;
    logic        serial_clock;
    logic        chip_select;
    logic        serial_data_in;
    logic        serial_data_out;
    logic        serial_data_out_oe_n;
    logic        res_stb;
    logic [15:0] res_word;
    logic [15:0] e_w;
    logic [15:0] exp_q[$];
    int          err_count = 0;
    int          tests_run = 0;
    int          seed = 97919;
    // The line has a pull-up, so a released output reads as one.
    wire logic   sdo_line = serial_data_out_oe_n ? 1'b1 : serial_data_out;
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        lnk_osc = 1'b0;
        #7;
        forever #40 lnk_osc = ~lnk_osc;
    end
    sec_port #(.PROG_CYCLES(PROG)) i_dut (.sys_clk(sys_clk), .srst(srst), .serial_clock(serial_clock),
        .chip_select(chip_select), .serial_data_in(serial_data_in), .word_width_select(word_width_select),
        .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n));
    sec_host i_host (.lnk_osc(lnk_osc), .sdo_line(sdo_line), .serial_clock(serial_clock),
        .chip_select(chip_select), .serial_data_in(serial_data_in), .res_stb(res_stb), .res_word(res_word));
    always @(posedge res_stb) begin
        e_w = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
        `CHK(res_word, e_w)
    end
    task automatic end_of_test;
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic do_reset;
        srst = 1'b1;
        fork
            repeat (6) @(posedge sys_clk);
            i_host.idle_pulses(4);
        join
        @(posedge sys_clk) #1;
        srst = 1'b0;
        // The link side leaves reset only on its own clock, so give it two idle edges.
        i_host.idle_pulses(2);
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic cmd(input logic [1:0] op, input logic [8:0] adr, input logic [15:0] dat, input int dn, input bit keep);
        int al;
        al = word_width_select ? 8 : 9;
        i_host.frame(((32'h0000_0004 | op) << (al + dn)) | ({23'h00_0000, adr} << dn) | dat, 3 + al + dn, keep);
    endtask
    function automatic logic [8:0] sub_adr(input logic [1:0] s);
        return word_width_select ? {1'b0, s, 6'h00} : {s, 7'h00};
    endfunction
    task automatic prog(input logic [1:0] op, input logic [8:0] adr, input logic [15:0] dat, input int dn);
        cmd(op, adr, dat, dn, 0);
        exp_q.push_back(16'h0000);
        exp_q.push_back(16'h0001);
        i_host.await_ready();
    endtask
    task automatic rd(input logic [8:0] adr, input logic [15:0] e0, input logic [15:0] e1, input int n);
        exp_q.push_back(16'h0000);
        exp_q.push_back(e0);
        if (n > 1) exp_q.push_back(e1);
        cmd(sec_pkg::OP_READ, adr, 16'h0000, 0, 1);
        i_host.fetch(n, word_width_select ? 16 : 8);
    endtask
    initial begin
        logic [15:0] d;
        logic [15:0] e;
        word_width_select = 1'b0;
        do_reset();
        d = 16'($random(seed)) & 16'h00FF;
        e = 16'($random(seed)) & 16'h00FF;
        cmd(sec_pkg::OP_WRITE, 9'h010, d, 8, 0);
        rd(9'h010, 16'h00FF, 16'h0000, 1);
        cmd(sec_pkg::OP_EXT, sub_adr(sec_pkg::SUB_UNLOCK), 16'h0000, 0, 0);
        prog(sec_pkg::OP_WRITE, 9'h010, d, 8);
        rd(9'h010, d, 16'h0000, 1);
        prog(sec_pkg::OP_WRITE, 9'h0FF, e, 8);
        prog(sec_pkg::OP_WRITE, 9'h000, d ^ 16'h005A, 8);
        i_host.hold_extra = 5;
        rd(9'h0FF, e, d ^ 16'h005A, 2);
        i_host.hold_extra = 0;
        prog(sec_pkg::OP_ERASE, 9'h010, 16'h0000, 0);
        rd(9'h010, 16'h00FF, 16'h0000, 1);
        cmd(sec_pkg::OP_WRITE, 9'h020, d & 16'h007F, 7, 0);
        cmd(sec_pkg::OP_WRITE, 9'h020, {d[7:0], 1'b1}, 9, 0);
        rd(9'h020, 16'h00FF, 16'h0000, 1);
        prog(sec_pkg::OP_EXT, sub_adr(sec_pkg::SUB_FILL), e, 8);
        rd(9'h055, e, e, 2);
        prog(sec_pkg::OP_EXT, sub_adr(sec_pkg::SUB_CLEAR), 16'h0000, 0);
        rd(9'h055, 16'h00FF, 16'h00FF, 2);
        cmd(sec_pkg::OP_EXT, sub_adr(sec_pkg::SUB_LOCK), 16'h0000, 0, 0);
        cmd(sec_pkg::OP_WRITE, 9'h030, d, 8, 0);
        rd(9'h030, 16'h00FF, 16'h0000, 1);
        word_width_select = 1'b1;
        do_reset();
        d = 16'($random(seed));
        cmd(sec_pkg::OP_EXT, sub_adr(sec_pkg::SUB_UNLOCK), 16'h0000, 0, 0);
        prog(sec_pkg::OP_WRITE, 9'h07F, d, 16);
        rd(9'h07F, d, 16'hFFFF, 2);
        end_of_test();
    end
    // Roughly thirty frames of a few microseconds each; this leaves ample margin.
    initial begin
        #1_500_000;
        err_count++;
        end_of_test();
    end
endmodule
`undef CHK
`default_nettype wire
